// File: logic/acs_top.sv
// The implementer's own choices: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module acs_top (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic converter_power_enable,
  output logic converter_reset,
  output logic converter_clock,
  output logic sampling,
  output logic converting,
  output logic conversion_busy_flag,
  output logic irq_request,
  output logic converter_irq,
  output logic ref_avdd,
  output logic ref_ext,
  output logic ref_bandgap,
  output logic [2:0] ref_multiple,
  output logic reference_buffer_enable,
  output logic bandgap_buffer_enable
);
  // Register state
  logic [2:0] ctrl0_reg, ctrl0_next;
  logic [2:0] ctrl1_reg, ctrl1_next;
  logic [7:0] ctrl2_reg, ctrl2_next;
  logic irq_flag_reg, irq_flag_next;
  logic irq_out_reg, irq_out_next;
  acs_pkg::acs_ref_s ref_reg, ref_next;

  // Bus state
  logic wr_pend_reg, wr_pend_next;
  logic rd_pend_reg, rd_pend_next;
  logic [7:0] addr_reg, addr_next;
  logic [31:0] hrdata_reg, hrdata_next;
  logic hready_reg, hready_next;
  logic accept;
  logic [31:0] rd_word;

  acs_if u_if ();

  acs_seq u_seq (
    .core_clk(core_clk),
    .rst(rst),
    .bus(u_if)
  );

  acs_clkdiv u_div (
    .core_clk(core_clk),
    .rst(rst),
    .bus(u_if)
  );

  // Feed the sequencer and divider from control registers
  assign u_if.start = ctrl0_reg[acs_pkg::CTRL0_START_BIT];
  assign u_if.power_en = ctrl0_reg[acs_pkg::CTRL0_POWER_BIT];
  assign u_if.rate_code = ctrl1_reg;

  // Address phase accepted only while the bus is ready
  assign accept = hsel && htrans[1] && hready;

  // Read word; busy comes from the sequencer, never from a stored bit
  always_comb begin
    rd_word = 32'h0000_0000;
    case (addr_reg)
      acs_pkg::OFS_CTRL0: begin
        rd_word[acs_pkg::CTRL0_START_BIT] =
          ctrl0_reg[acs_pkg::CTRL0_START_BIT];
        rd_word[acs_pkg::CTRL0_POWER_BIT] =
          ctrl0_reg[acs_pkg::CTRL0_POWER_BIT];
        rd_word[acs_pkg::CTRL0_IRQEN_BIT] =
          ctrl0_reg[acs_pkg::CTRL0_IRQEN_BIT];
        rd_word[acs_pkg::CTRL0_BUSY_BIT] = u_if.busy;
      end
      acs_pkg::OFS_CTRL1: begin
        rd_word[acs_pkg::CTRL1_RATE_LSB +: 3] = ctrl1_reg;
      end
      acs_pkg::OFS_CTRL2: begin
        rd_word[7:0] = ctrl2_reg;
      end
      acs_pkg::OFS_STAT: begin
        rd_word[acs_pkg::STAT_IRQ_BIT] = irq_flag_reg;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Bus slave: writes take no wait, reads take one wait state
  always_comb begin
    wr_pend_next = accept && hwrite;
    rd_pend_next = accept && !hwrite;
    addr_next = accept ? {haddr[7:2], 2'b00} : addr_reg;
    hrdata_next = hrdata_reg;
    hready_next = 1'b1;
    if (accept && !hwrite) begin
      // Wait state gives the registered hrdata a cycle to load from rd_word
      hready_next = 1'b0;
    end
    if (rd_pend_reg) begin
      hrdata_next = rd_word;
    end
  end

  // Bus state registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      addr_reg <= 8'h00;
      hrdata_reg <= 32'h0000_0000;
      hready_reg <= 1'b1;
    end else begin
      wr_pend_reg <= wr_pend_next;
      rd_pend_reg <= rd_pend_next;
      addr_reg <= addr_next;
      hrdata_reg <= hrdata_next;
      hready_reg <= hready_next;
    end
  end

  // Register writes, status flag and interrupt output
  always_comb begin
    ctrl0_next = ctrl0_reg;
    ctrl1_next = ctrl1_reg;
    ctrl2_next = ctrl2_reg;
    irq_flag_next = irq_flag_reg;
    if (wr_pend_reg) begin
      case (addr_reg)
        acs_pkg::OFS_CTRL0: begin
          // Busy bit position is ignored on write
          ctrl0_next[acs_pkg::CTRL0_START_BIT] =
            hwdata[acs_pkg::CTRL0_START_BIT];
          ctrl0_next[acs_pkg::CTRL0_POWER_BIT] =
            hwdata[acs_pkg::CTRL0_POWER_BIT];
          ctrl0_next[acs_pkg::CTRL0_IRQEN_BIT] =
            hwdata[acs_pkg::CTRL0_IRQEN_BIT];
        end
        acs_pkg::OFS_CTRL1: begin
          ctrl1_next = hwdata[acs_pkg::CTRL1_RATE_LSB +: 3];
        end
        acs_pkg::OFS_CTRL2: begin
          ctrl2_next = hwdata[7:0] & acs_pkg::CTRL2_MASK;
        end
        acs_pkg::OFS_STAT: begin
          if (hwdata[acs_pkg::STAT_IRQ_BIT]) begin
            irq_flag_next = 1'b0;
          end
        end
        default: ;
      endcase
    end
    // Completion beats a clear in the same cycle
    if (u_if.done) begin
      irq_flag_next = 1'b1;
    end
    irq_out_next = irq_flag_reg &&
      ctrl0_reg[acs_pkg::CTRL0_IRQEN_BIT];
    ref_next = acs_pkg::ref_decode(
      ctrl2_reg[acs_pkg::CTRL2_REF_LSB +: 4]);
  end

  // Register file, flag and decoded reference flops
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl0_reg <= acs_pkg::CTRL0_RST;
      ctrl1_reg <= acs_pkg::CTRL1_RST;
      ctrl2_reg <= acs_pkg::CTRL2_RST;
      irq_flag_reg <= 1'b0;
      irq_out_reg <= 1'b0;
      ref_reg <= '{avdd: 1'b1, ext: 1'b0, bg: 1'b0, mult: 3'h1};
    end else begin
      ctrl0_reg <= ctrl0_next;
      ctrl1_reg <= ctrl1_next;
      ctrl2_reg <= ctrl2_next;
      irq_flag_reg <= irq_flag_next;
      irq_out_reg <= irq_out_next;
      ref_reg <= ref_next;
    end
  end

  // Bus outputs
  assign hrdata = hrdata_reg;
  assign hreadyout = hready_reg;
  assign hresp = 1'b0;

  // Converter side outputs, all flop driven
  assign converter_power_enable =
    ctrl0_reg[acs_pkg::CTRL0_POWER_BIT];
  assign converter_reset = u_if.conv_reset;
  assign converter_clock = u_if.tick;
  assign sampling = u_if.sampling;
  assign converting = u_if.converting;
  assign conversion_busy_flag = u_if.busy;
  assign irq_request = irq_flag_reg;
  assign converter_irq = irq_out_reg;
  assign ref_avdd = ref_reg.avdd;
  assign ref_ext = ref_reg.ext;
  assign ref_bandgap = ref_reg.bg;
  assign ref_multiple = ref_reg.mult;
  // Buffer enables are software's duty; passed through as written
  assign reference_buffer_enable = ctrl2_reg[acs_pkg::CTRL2_REFBUF_BIT];
  assign bandgap_buffer_enable = ctrl2_reg[acs_pkg::CTRL2_BGEN_BIT];

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_read_phase;
    !hreadyout ##1 hreadyout;
  endsequence

  a_read_wait: assert property (
    (hsel && htrans[1] && hready && !hwrite) |=> s_read_phase)
    else $error("read data phase not one wait state");
  a_irq_flag_set: assert property (
    u_if.done |=> irq_request ##1 (converter_irq ==
      ctrl0_reg[acs_pkg::CTRL0_IRQEN_BIT] || !irq_request))
    else $error("completion did not raise interrupt request");
  a_ref_bg_wins: assert property (
    ctrl2_reg[3] |=> ref_bandgap && !ref_ext && !ref_avdd)
    else $error("bandgap not chosen over external reference");
  a_ref_ext_map: assert property (
    (ctrl2_reg[3:0] == 4'h3) |=> ref_ext && ref_multiple == 3'h3)
    else $error("external times three not decoded");
  a_ref_bg_map: assert property (
    (ctrl2_reg[3:0] == 4'hc) |=> ref_bandgap && ref_multiple == 3'h4)
    else $error("bandgap times four not decoded");
  a_busy_readonly: assert property (
    (wr_pend_reg && addr_reg == acs_pkg::OFS_CTRL0 && !u_if.start &&
     !hwdata[acs_pkg::CTRL0_START_BIT] && !u_if.busy && !u_if.conv_reset)
    |=> !conversion_busy_flag)
    else $error("software write set the busy flag");
  a_power_follow: assert property (
    (wr_pend_reg && addr_reg == acs_pkg::OFS_CTRL0) |=>
    converter_power_enable == $past(hwdata[acs_pkg::CTRL0_POWER_BIT]))
    else $error("power enable did not follow the write");

  // Bus answer timing and read data
  a_write_no_wait: assert property (
    (hsel && htrans[1] && hready && hwrite) |=> hreadyout)
    else $error("write data phase held a wait state");
  a_read_load: assert property (
    rd_pend_reg |=> hrdata == $past(rd_word))
    else $error("read data not loaded in the wait state");
  a_read_hold: assert property (
    !rd_pend_reg |=> $stable(hrdata))
    else $error("read data changed outside a read");
  a_resp_okay: assert property (
    hresp == 1'b0)
    else $error("slave response not okay");
  a_ctrl1_write: assert property (
    (wr_pend_reg && addr_reg == acs_pkg::OFS_CTRL1) |=>
    ctrl1_reg == $past(hwdata[2:0]))
    else $error("rate code did not follow the write");
  a_ctrl2_pad: assert property (
    ctrl2_reg[5:4] == 2'b00)
    else $error("unused reference bits not zero");

  // Start and interrupt enable follow their writes
  a_start_follow: assert property (
    (wr_pend_reg && addr_reg == acs_pkg::OFS_CTRL0) |=>
    u_if.start == $past(hwdata[acs_pkg::CTRL0_START_BIT]))
    else $error("start bit did not follow the write");
  a_irqen_follow: assert property (
    (wr_pend_reg && addr_reg == acs_pkg::OFS_CTRL0) |=>
    ctrl0_reg[acs_pkg::CTRL0_IRQEN_BIT] ==
    $past(hwdata[acs_pkg::CTRL0_IRQEN_BIT]))
    else $error("interrupt enable did not follow the write");

  // Flag is sticky until a write of one clears it
  a_irq_clear: assert property (
    (wr_pend_reg && addr_reg == acs_pkg::OFS_STAT &&
     hwdata[acs_pkg::STAT_IRQ_BIT] && !u_if.done) |=> !irq_request)
    else $error("interrupt flag not cleared by write of one");
  a_irq_sticky: assert property (
    (irq_request && !(wr_pend_reg && addr_reg == acs_pkg::OFS_STAT &&
     hwdata[acs_pkg::STAT_IRQ_BIT])) |=> irq_request)
    else $error("interrupt flag dropped without a clear");
  a_irq_gate_on: assert property (
    (irq_request && ctrl0_reg[acs_pkg::CTRL0_IRQEN_BIT]) |=>
    converter_irq)
    else $error("enabled interrupt not raised");
  a_irq_gate_off: assert property (
    !(irq_request && ctrl0_reg[acs_pkg::CTRL0_IRQEN_BIT]) |=>
    !converter_irq)
    else $error("interrupt raised while flag or enable low");

  // Reference decode, one source at a time
  a_ref_onehot: assert property (
    $onehot({ref_avdd, ref_ext, ref_bandgap}))
    else $error("reference source not one-hot");
  a_ref_avdd_map: assert property (
    (ctrl2_reg[3:0] == 4'h0) |=> ref_avdd && ref_multiple == 3'h1)
    else $error("analog supply reference not decoded");
  a_ref_ext_times: assert property (
    (ctrl2_reg[3:0] >= 4'h1 && ctrl2_reg[3:0] <= 4'h4) |=>
    ref_ext && ref_multiple == $past(ctrl2_reg[2:0]))
    else $error("external reference multiple not decoded");
  a_ref_bg_two: assert property (
    (ctrl2_reg[3:0] == 4'ha) |=> ref_bandgap && ref_multiple == 3'h2)
    else $error("bandgap times two not decoded");
  a_ref_bg_three: assert property (
    (ctrl2_reg[3:0] == 4'hb) |=> ref_bandgap && ref_multiple == 3'h3)
    else $error("bandgap times three not decoded");

  // Converter status outputs
  a_reset_no_run: assert property (
    converter_reset |-> !sampling && !converting && !conversion_busy_flag)
    else $error("converter running while held in reset");
  a_busy_phases: assert property (
    conversion_busy_flag == (sampling || converting))
    else $error("busy flag not covering sample and convert");
endmodule
`default_nettype wire

// File: common/acs_pkg.sv
// Function
// - Start bit going high then low launches one conversion.
// - While start is high, converter held in reset and busy forced low.
// - Busy flag goes high by itself once a conversion is launched.
// - Busy flag clears when the conversion finishes.
// - Completion sets interrupt request flag; enabled flag raises converter interrupt.
// - Converter circuitry powered only while power enable is high.
// - Codes 0000 supply, 0001 external, 0010-0100 external times two to four.
// - Codes 1010, 1011, 1100 give bandgap times two, three, four.
// - External and bandgap selected together means bandgap alone is used.
// - Converter clock is system clock divided by two to the code power.
// - Conversion is four clocks sampling then twelve converting, busy throughout.
package acs_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL0 = 8'h00;
  localparam logic [7:0] OFS_CTRL1 = 8'h04;
  localparam logic [7:0] OFS_CTRL2 = 8'h08;
  localparam logic [7:0] OFS_STAT = 8'h0c;
  // Control 0 fields
  localparam int CTRL0_START_BIT = 0;
  localparam int CTRL0_POWER_BIT = 1;
  localparam int CTRL0_IRQEN_BIT = 2;
  localparam int CTRL0_BUSY_BIT = 7;
  localparam logic [2:0] CTRL0_RST = 3'h0;
  // Control 1 fields
  localparam int CTRL1_RATE_LSB = 0;
  localparam logic [2:0] CTRL1_RST = 3'h0;
  // Control 2 fields
  localparam int CTRL2_REF_LSB = 0;
  localparam int CTRL2_BGEN_BIT = 6;
  localparam int CTRL2_REFBUF_BIT = 7;
  localparam logic [7:0] CTRL2_MASK = 8'hcf;
  localparam logic [7:0] CTRL2_RST = 8'h00;
  // Status fields
  localparam int STAT_IRQ_BIT = 0;
  // Conversion phase lengths in converter clocks
  localparam logic [3:0] SAMPLE_CYCLES = 4'h4;
  localparam logic [3:0] CONVERT_CYCLES = 4'hc;
  localparam logic [4:0] TOTAL_CYCLES = 5'h10;

  typedef struct packed {
    logic avdd;
    logic ext;
    logic bg;
    logic [2:0] mult;
  } acs_ref_s;

  // Reference code to source and multiple
  function automatic acs_ref_s ref_decode(input logic [3:0] code);
    acs_ref_s r;
    r = '{avdd: 1'b1, ext: 1'b0, bg: 1'b0, mult: 3'h1};
    if (code[3]) begin
      // Bandgap wins whenever its bit is set
      r = '{avdd: 1'b0, ext: 1'b0, bg: 1'b1, mult: 3'h2};
      if (code[2:0] == 3'h3) begin
        r.mult = 3'h3;
      end else if (code[2:0] >= 3'h4) begin
        r.mult = 3'h4;
      end
    end else if (code[2:0] != 3'h0 && code[2:0] <= 3'h4) begin
      r = '{avdd: 1'b0, ext: 1'b1, bg: 1'b0, mult: code[2:0]};
    end
    return r;
  endfunction
endpackage

// File: common/acs_if.sv
`timescale 1ns/1ps
`default_nettype none
// Links the register block to sequencer and clock divider
interface acs_if;
  logic start;
  logic power_en;
  logic [2:0] rate_code;
  logic tick;
  logic clr;
  logic busy;
  logic conv_reset;
  logic sampling;
  logic converting;
  logic done;

  modport seq (
    input start,
    input power_en,
    input tick,
    output clr,
    output busy,
    output conv_reset,
    output sampling,
    output converting,
    output done
  );
  modport div (
    input rate_code,
    input clr,
    output tick
  );
endinterface
`default_nettype wire

// File: logic/acs_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module acs_clkdiv (
  input wire logic core_clk,
  input wire logic rst,
  acs_if.div bus
);
  logic [6:0] cnt_reg, cnt_next;
  logic tick_reg, tick_next;
  logic [7:0] limit8;
  logic [6:0] limit;

  // One tick per 2**code system clocks, restarted by clr
  always_comb begin
    limit8 = (8'h01 << bus.rate_code) - 8'h01;
    limit = limit8[6:0];
    tick_next = 1'b0;
    cnt_next = cnt_reg + 7'h01;
    if (bus.clr) begin
      cnt_next = 7'h00;
    end else if (cnt_reg >= limit) begin
      // >= keeps a shrinking code from running the count away
      cnt_next = 7'h00;
      tick_next = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg <= 7'h00;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      tick_reg <= tick_next;
    end
  end

  assign bus.tick = tick_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  a_div_by_eight: assert property (
    (bus.tick && !bus.clr && bus.rate_code == 3'h3) |=>
    (!bus.tick || bus.clr || bus.rate_code != 3'h3) [*7] ##1
    (bus.tick || bus.clr || bus.rate_code != 3'h3))
    else $error("converter clock period wrong for divide by eight");
endmodule
`default_nettype wire

// File: logic/acs_seq.sv
`timescale 1ns/1ps
`default_nettype none
module acs_seq (
  input wire logic core_clk,
  input wire logic rst,
  acs_if.seq bus
);
  typedef enum logic [1:0] {ST_IDLE, ST_HOLD, ST_SAMPLE, ST_CONVERT} acs_seq_e;
  acs_seq_e state_reg, state_next;
  logic [3:0] cnt_reg, cnt_next;
  logic done_reg, done_next;
  logic [4:0] tk_reg;
  logic hold_reg, hold_next, samp_reg, samp_next;
  logic conv_reg, conv_next, busy_reg, busy_next;

  // Start level has priority, then power, then the phase counts
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    done_next = 1'b0;
    if (bus.start) begin
      state_next = ST_HOLD;
    end else if (!bus.power_en) begin
      state_next = ST_IDLE;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          state_next = ST_SAMPLE;
          cnt_next = 4'h0;
        end
        ST_SAMPLE: begin
          if (bus.tick) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == acs_pkg::SAMPLE_CYCLES - 4'h1) begin
              state_next = ST_CONVERT;
              cnt_next = 4'h0;
            end
          end
        end
        ST_CONVERT: begin
          if (bus.tick) begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == acs_pkg::CONVERT_CYCLES - 4'h1) begin
              state_next = ST_IDLE;
              done_next = 1'b1;
            end
          end
        end
        default: state_next = ST_IDLE;
      endcase
    end
    // Status taken from the next state, so flops match the state decode
    hold_next = (state_next == ST_HOLD);
    samp_next = (state_next == ST_SAMPLE);
    conv_next = (state_next == ST_CONVERT);
    busy_next = samp_next || conv_next;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
      hold_reg <= 1'b0;
      samp_reg <= 1'b0;
      conv_reg <= 1'b0;
      busy_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      hold_reg <= hold_next;
      samp_reg <= samp_next;
      conv_reg <= conv_next;
      busy_reg <= busy_next;
    end
  end

  // Each status output is its own flop, so no decode glitch reaches a pin
  assign bus.busy = busy_reg;
  assign bus.conv_reset = hold_reg;
  assign bus.sampling = samp_reg;
  assign bus.converting = conv_reg;
  assign bus.clr = !bus.busy;
  assign bus.done = done_reg;

  // Helper: ticks seen while busy
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tk_reg <= 5'h00;
    end else begin
      tk_reg <= bus.busy ? tk_reg + {4'h0, bus.tick} : 5'h00;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_hold;
    bus.start ##1 !bus.start && bus.power_en;
  endsequence

  a_hold_no_busy: assert property (
    bus.start |=> bus.conv_reset && !bus.busy)
    else $error("busy or run while start held high");
  a_launch_busy: assert property (
    s_hold |=> bus.busy && bus.sampling)
    else $error("busy not set after start released");
  a_sixteen_ticks: assert property (
    bus.done |-> tk_reg == acs_pkg::TOTAL_CYCLES && !bus.busy)
    else $error("conversion did not span sixteen converter clocks");
  a_power_idle: assert property (
    (!bus.power_en && !bus.start) |=> !bus.busy && !bus.conv_reset)
    else $error("sequencer running with power off");
endmodule
`default_nettype wire

// File: testbench/acs_top_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module acs_top_tb_top;
  localparam logic [7:0] A0 = acs_pkg::OFS_CTRL0;
  localparam logic [7:0] A1 = acs_pkg::OFS_CTRL1;
  localparam logic [7:0] A2 = acs_pkg::OFS_CTRL2;
  localparam logic [7:0] AS = acs_pkg::OFS_STAT;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, converter_power_enable, converter_reset;
  logic converter_clock, sampling, converting, conversion_busy_flag;
  logic irq_request, converter_irq, ref_avdd, ref_ext, ref_bandgap;
  logic [2:0] ref_multiple;
  logic reference_buffer_enable, bandgap_buffer_enable;
  int n_errors = 0;
  int n_compared = 0;
  int k;

  // Free-running system clock, 100 ns period
  always #50 core_clk = ~core_clk;

  // Single slave, so its ready output is the bus ready
  acs_top DUT (
    .core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout),
    .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .converter_power_enable(converter_power_enable),
    .converter_reset(converter_reset), .converter_clock(converter_clock),
    .sampling(sampling), .converting(converting),
    .conversion_busy_flag(conversion_busy_flag),
    .irq_request(irq_request), .converter_irq(converter_irq),
    .ref_avdd(ref_avdd), .ref_ext(ref_ext), .ref_bandgap(ref_bandgap),
    .ref_multiple(ref_multiple),
    .reference_buffer_enable(reference_buffer_enable),
    .bandgap_buffer_enable(bandgap_buffer_enable)
  );

  // Counts, verdict and end of run
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp,
                     input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Ready is looked at before the edge, so the edge itself never races
  task automatic wait_ready(output logic [31:0] rd);
    logic r;
    int i;
    r = 1'b0;
    rd = 32'h0;
    for (i = 0; i < 20 && !r; i++) begin
      @(negedge core_clk);
      r = hreadyout;
      rd = hrdata;
      @(posedge core_clk);
    end
    if (r !== 1'b1) begin
      n_errors++;
      $display("[FAIL] hready expected 1 seen %b", r);
      close_out();
    end
  endtask

  // One single transfer; entered and left just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    wait_ready(rd);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready(rd);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, a, d, x);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a,
                       input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h0, x);
    chk(what, exp, x);
  endtask

  // Wait whole cycles, then stop between edges on a falling edge to look
  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  // Expected {avdd, ext, bandgap, multiple}; bandgap bit wins
  function automatic logic [5:0] exp_ref(input logic [3:0] c);
    if (c == 4'h0 || (c >= 4'h5 && c <= 4'h7)) return {3'b100, 3'h1};
    if (c <= 4'h4) return {3'b010, c[2:0]};
    if (c == 4'hb) return {3'b001, 3'h3};
    if (c >= 4'hc) return {3'b001, 3'h4};
    return {3'b001, 3'h2};
  endfunction

  // Full start sequence at one rate, pulses counted between edges
  task automatic conv(input logic [2:0] rate, input logic ie);
    int i;
    int last;
    int sp;
    int cp;
    logic seen;
    seen = 1'b0;
    last = -1;
    sp = 0;
    cp = 0;
    wr(A1, {29'h0, rate});
    wr(A0, {29'h0, ie, 2'h3});
    rdchk("ctrl0 held", A0, {29'h0, ie, 2'h3});
    look(20);
    chk("reset held", 32'h1, {31'h0, converter_reset});
    chk("busy held", 32'h0, {31'h0, conversion_busy_flag});
    chk("power", 32'h1, {31'h0, converter_power_enable});
    @(posedge core_clk);
    wr(A0, {29'h0, ie, 2'h2});
    for (i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (converter_clock === 1'b1 && conversion_busy_flag === 1'b1) begin
        if (sampling === 1'b1) sp++;
        else if (converting === 1'b1) cp++;
        if (last >= 0) chk("clock gap", 32'h1 << rate, 32'(i - last));
        last = i;
      end
      if (conversion_busy_flag === 1'b1) seen = 1'b1;
      if (seen && conversion_busy_flag !== 1'b1) break;
    end
    if (i == 3000) begin
      n_errors++;
      $display("[FAIL] busy end expected 0 seen %b", conversion_busy_flag);
      close_out();
    end
    chk("sample pulses", 32'd4, 32'(sp));
    chk("convert pulses", 32'd12, 32'(cp));
    look(2);
    chk("irq flag", 32'h1, {31'h0, irq_request});
    chk("irq out", {31'h0, ie}, {31'h0, converter_irq});
    @(posedge core_clk);
    rdchk("stat set", AS, 32'h1);
    rdchk("ctrl0 done", A0, {29'h0, ie, 2'h2});
    wr(AS, 32'h1);
    rdchk("stat clear", AS, 32'h0);
    look(0);
    chk("irq out clear", 32'h0, {31'h0, converter_irq});
    @(posedge core_clk);
  endtask

  // Main sequence
  initial begin
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdchk("ctrl0 rst", A0, 32'h0);
    rdchk("ctrl1 rst", A1, 32'h0);
    rdchk("ctrl2 rst", A2, 32'h0);
    rdchk("stat rst", AS, 32'h0);
    look(0);
    chk("ref rst", 32'h21, {26'h0, exp_ref(4'h0)});
    chk("ref out rst", 32'h21,
        {26'h0, ref_avdd, ref_ext, ref_bandgap, ref_multiple});
    chk("hresp", 32'h0, {31'h0, hresp});
    @(posedge core_clk);
    // Every selector code, reserved ones too; bits 5:4 must read 0
    for (k = 0; k < 16; k++) begin
      wr(A2, {24'h0, 4'hf, 4'(k)});
      rdchk("ctrl2", A2, {24'h0, 4'hc, 4'(k)});
      look(0);
      chk("ref", {26'h0, exp_ref(4'(k))},
          {26'h0, ref_avdd, ref_ext, ref_bandgap, ref_multiple});
      chk("buffers", 32'h3,
          {30'h0, reference_buffer_enable, bandgap_buffer_enable});
      @(posedge core_clk);
    end
    // All eight divider codes, interrupt enable alternating
    for (k = 0; k < 8; k++) begin
      conv(3'(k), k[0]);
    end
    // Start pulse with power off must not launch
    wr(A0, 32'h0);
    wr(A0, 32'h1);
    wr(A0, 32'h0);
    look(40);
    chk("unpowered busy", 32'h0, {31'h0, conversion_busy_flag});
    chk("power off", 32'h0, {31'h0, converter_power_enable});
    @(posedge core_clk);
    // Restart mid-conversion, then abort by power off
    wr(A1, 32'h6);
    wr(A0, 32'h3);
    look(20);
    @(posedge core_clk);
    wr(A0, 32'h2);
    look(50);
    chk("busy launched", 32'h1, {31'h0, conversion_busy_flag});
    @(posedge core_clk);
    wr(A0, 32'h3);
    look(1);
    chk("restart busy", 32'h0, {31'h0, conversion_busy_flag});
    chk("restart reset", 32'h1, {31'h0, converter_reset});
    @(posedge core_clk);
    wr(A0, 32'h2);
    wr(A0, 32'h0);
    look(1);
    chk("abort busy", 32'h0, {31'h0, conversion_busy_flag});
    look(1100);
    chk("abort flag", 32'h0, {31'h0, irq_request});
    @(posedge core_clk);
    // Busy bit cannot be written; unmapped place reads 0
    wr(A0, 32'h80);
    rdchk("ctrl0 busy ro", A0, 32'h0);
    wr(8'h10, 32'hffffffff);
    rdchk("unmapped", 8'h10, 32'h0);
    rdchk("ctrl1 kept", A1, 32'h6);
    close_out();
  end
endmodule
`default_nettype wire
